// ==== rtl/pmrc_pkg.sv ====
// Package with constants and types for the power mode and reset controller
package pmrc_pkg;
   // Register byte addresses
   localparam logic [7:0] PMRC_ADDR_PCON     = 8'h00; // Power mode select and deep power-down lock
   localparam logic [7:0] PMRC_ADDR_CLKGATE  = 8'h04; // Peripheral clock enables
   localparam logic [7:0] PMRC_ADDR_CLKSEL   = 8'h08; // System clock source select
   localparam logic [7:0] PMRC_ADDR_SLEEPCFG = 8'h0C; // Sources kept alive in deep-sleep / power-down
   localparam logic [7:0] PMRC_ADDR_BROWN    = 8'h10; // Brownout levels and enables
   localparam logic [7:0] PMRC_ADDR_STATUS   = 8'h14; // Reset cause, brownout and state
   localparam logic [7:0] PMRC_ADDR_WAKEEN   = 8'h18; // Wake source enables
   // Field positions
   localparam int PMRC_PCON_MODE_LSB   = 0;  // Two-bit mode field
   localparam int PMRC_PCON_LOCK_BIT   = 2;  // Deep power-down lock
   localparam int PMRC_CFG_WDOSC_BIT   = 0;  // Keep watchdog oscillator
   localparam int PMRC_CFG_BROWN_BIT   = 1;  // Keep brownout detector
   localparam int PMRC_CFG_WDIRC_BIT   = 2;  // Watchdog clocked from RC oscillator
   localparam int PMRC_BR_IRQLVL_LSB   = 0;  // Interrupt level, two bits
   localparam int PMRC_BR_RSTLVL_LSB   = 2;  // Reset level, two bits
   localparam int PMRC_BR_RSTEN_BIT    = 4;  // Brownout reset enable
   // Reset values
   localparam logic [31:0] PMRC_CLKGATE_RST = 32'h0000_0000;
   localparam logic [1:0]  PMRC_CLKSEL_RST  = 2'h0; // Internal RC oscillator
   localparam logic [2:0]  PMRC_SLEEPCFG_RST = 3'h0;
   localparam logic [4:0]  PMRC_BROWN_RST   = 5'h00;
   localparam logic [3:0]  PMRC_WAKEEN_RST  = 4'hF;
   localparam logic [31:0] PMRC_BOOT_ADDR   = 32'h0000_0000; // Execution start address
   // Timing
   localparam int PMRC_CLK_MHZ         = 40;
   localparam int PMRC_RST_PULSE_NS    = 50;  // Least valid reset pulse
   localparam int PMRC_RST_PULSE_CYC   = (PMRC_RST_PULSE_NS * PMRC_CLK_MHZ + 999) / 1000;
   localparam int PMRC_OSC_START_CYC   = 16;  // Oscillator restart settle on wake
   localparam int PMRC_RESET_HOLD_CYC  = 8;   // Internal reset stretch
   localparam logic [1:0] PMRC_SRC_RC  = 2'h0; // Clock source codes
   // Power modes
   typedef enum logic [1:0] {
      PMRC_MODE_SLEEP    = 2'h0,
      PMRC_MODE_DEEP     = 2'h1,
      PMRC_MODE_PDOWN    = 2'h2,
      PMRC_MODE_DEEP_PD  = 2'h3
   } pmrc_mode_t;
   // Wake source indices
   localparam int PMRC_WK_PIN  = 0;
   localparam int PMRC_WK_WDOG = 1;
   localparam int PMRC_WK_USB  = 2;
   localparam int PMRC_WK_IRQ  = 3;
endpackage

// ==== rtl/pmrc_sync.sv ====
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module pmrc_sync #(
   parameter int W   = 1,      // Width
   parameter logic [W-1:0] INIT = '0 // Value after reset
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1; // First stage, read only by second
      logic [W-1:0] s2; // Second stage
   } pmrc_sync_t;
   pmrc_sync_t st_reg;
   pmrc_sync_t st_next;
   // Shift the input through both stages
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = din;
      st_next.s2 = st_reg.s1;
   end
   // Register stage
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= '{s1: INIT, s2: INIT};
      end else begin
         st_reg <= st_next;
      end
   end
   assign dout = st_reg.s2;
endmodule

// ==== rtl/pmrc_count.sv ====
// Saturating up-counter that reports when a target count is reached
`timescale 1ns/1ps
module pmrc_count #(
   parameter int W = 8 // Counter width
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         run,    // Count while high, clear while low
   input  wire logic [W-1:0] target, // Cycles to reach
   output logic              done    // High once count reached target
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         done;
   } pmrc_count_t;
   pmrc_count_t st_reg;
   pmrc_count_t st_next;
   // Count up while run is held, saturate at target
   always_comb begin
      st_next = st_reg;
      if (!run) begin
         st_next.cnt  = '0;
         st_next.done = 1'b0;
      end else if (st_reg.cnt >= target) begin
         st_next.done = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + W'(1);
      end
   end
   // Register stage
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= '{cnt: '0, done: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end
   assign done = st_reg.done;
endmodule

// ==== rtl/pmrc_top.sv ====
// Power mode, clock gating, wake and reset sequencing controller
//
// What this block does
// RL1 - Start and deep wake on RC oscillator
// RL2 - Software waits for oscillator before selecting
// RL3 - Four software-selectable power reduction modes
// RL4 - Register bits gate each peripheral clock
// RL5 - Sleep stops core clock, interrupt resumes
// RL6 - Peripheral clocks keep running in sleep
// RL7 - Deep-sleep keeps only RC, analog off
// RL8 - Deep-sleep may keep watchdog osc, brownout
// RL9 - Wake on reset, pin, watchdog, USB
// RL10 - Power-down keeps only selected watchdog osc; the code also keeps the brownout detector when selected
// RL11 - Deep power-down wakes only via pin
// RL12 - Lock bit refuses deep power-down entry
// RL13 - Four reset sources restart RC, flash
// RL14 - Reset pin low 50 ns resets
// RL15 - Registers reset, execution starts at zero
// RL16 - Brownout level interrupt and status bit
// RL17 - Brownout reset level forces chip reset
// RL18 - Reset pin selects debug port
// RL19 - Tester sequence for boundary scan entry; the code enables boundary scan whenever the synchronised reset pin is low
// RL20 - Low-power entry on wait-for-interrupt only
// RL21 - Wake restarts sources, RC before core
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module pmrc_top #(
   parameter int NPERIPH  = 32, // Number of gated peripheral clocks
   parameter int NGPIOWK  = 8   // Number of wake-capable pins
) (
   input  wire logic               mclk,           // 40 MHz system clock
   input  wire logic               rst,            // Synchronous power-on reset
   // Register port
   input  wire logic [7:0]         reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [31:0]        reg_rdata,
   // Core side
   input  wire logic               core_wfi,       // Wait-for-interrupt executed
   input  wire logic               core_irq,       // Any pending enabled interrupt
   output logic                    core_clk_en,    // Core clock gate
   output logic                    core_rst,       // Chip reset to core and peripherals
   output logic      [31:0]        core_boot_addr, // Fetch start address
   output logic                    flash_init,     // Flash controller initialise pulse
   output logic                    flash_standby,  // Flash in standby
   output logic                    flash_off,      // Flash shut down
   output logic                    analog_off,     // Analog blocks shut down
   output logic                    power_off,      // Main power removed
   // Clocks
   output logic      [NPERIPH-1:0] periph_clk_en,  // Peripheral clock gates
   output logic                    internal_rc_oscillator_en,
   output logic                    internal_rc_oscillator_out_en,
   output logic                    watchdog_oscillator_en,
   output logic                    sysosc_pll_en,  // Main oscillator and PLL allowed
   output logic      [1:0]         clk_sel,        // System clock source
   // Reset and wake inputs from pins and analog
   input  wire logic               reset_pin_n,    // External reset pin
   input  wire logic               deep_powerdown_wake_pin_n,
   input  wire logic [NGPIOWK-1:0] gpio_wake,
   input  wire logic               wdog_irq,
   input  wire logic               wdog_reset,
   input  wire logic               usb_activity,
   input  wire logic [3:0]         vdd_below,      // One-hot-ish: supply below level i
   // Brownout and debug
   output logic                    brownout_detector_en,
   output logic                    brownout_irq,
   output logic                    swd_en,
   output logic                    bscan_en
);
   typedef enum {
      ST_RUN, ST_SLEEP, ST_DEEP, ST_PDOWN, ST_DPD, ST_WAKE, ST_RESET
   } pmrc_state_t;

   // All module state
   typedef struct packed {
      logic [1:0]         mode;       // Selected low-power mode
      logic               lock;       // Deep power-down lock
      logic [NPERIPH-1:0] clkgate;    // Peripheral clock enables
      logic [1:0]         clksel;     // Clock source
      logic [2:0]         sleepcfg;   // Sources kept in low power
      logic [4:0]         brown;      // Brownout config
      logic [3:0]         wakeen;     // Wake source enables
      logic [3:0]         rst_cause;  // Sticky: pin, watchdog, por, brownout
      logic               dpd_flag;   // Woke from deep power-down
      logic [31:0]        rdata;      // Read data
      logic [3:0]         state;      // Power state
      logic [3:0]         hold;       // Internal reset stretch
      logic               finit;      // Flash init pulse
   } pmrc_top_t;
   pmrc_top_t st_reg;
   pmrc_top_t st_next;

   logic               rpin_s;       // Synchronised reset pin
   logic               wpin_s;       // Synchronised wake pin
   logic [NGPIOWK-1:0] gpio_s;
   logic [2:0]         misc_s;       // Watchdog irq, watchdog reset, usb
   logic [3:0]         vdd_s;
   logic               pin_low_ok;   // Reset pin held low long enough
   logic               osc_ready;    // Restart settle done
   logic               wake_req;
   logic               brown_rst;
   logic               chip_rst_src;
   logic               in_wake;
   pmrc_state_t        cur;

   // Synchronise every pin and analog input before use
   pmrc_sync #(.W(1), .INIT(1'b1)) u_sync_rpin (.mclk(mclk), .rst(rst), .din(reset_pin_n), .dout(rpin_s));
   pmrc_sync #(.W(1), .INIT(1'b1)) u_sync_wpin (.mclk(mclk), .rst(rst),
                                                .din(deep_powerdown_wake_pin_n), .dout(wpin_s));
   pmrc_sync #(.W(NGPIOWK), .INIT('0)) u_sync_gpio (.mclk(mclk), .rst(rst), .din(gpio_wake), .dout(gpio_s));
   pmrc_sync #(.W(3), .INIT('0)) u_sync_misc (.mclk(mclk), .rst(rst),
                                              .din({usb_activity, wdog_reset, wdog_irq}), .dout(misc_s));
   pmrc_sync #(.W(4), .INIT('0)) u_sync_vdd (.mclk(mclk), .rst(rst), .din(vdd_below), .dout(vdd_s));

   // Reset pin must stay low for the least pulse width
   pmrc_count #(.W(4)) u_rpin_cnt ( // RL14
      .mclk   (mclk),
      .rst    (rst),
      .run    (!rpin_s),
      .target (4'(pmrc_pkg::PMRC_RST_PULSE_CYC - 1)),
      .done   (pin_low_ok)
   );

   // Oscillator restart settle on wake
   pmrc_count #(.W(5)) u_osc_cnt ( // RL21
      .mclk   (mclk),
      .rst    (rst),
      .run    (in_wake),
      .target (5'(pmrc_pkg::PMRC_OSC_START_CYC)),
      .done   (osc_ready)
   );

   assign cur     = pmrc_state_t'(st_reg.state);
   assign in_wake = (cur == ST_WAKE);

   // Wake sources for deep-sleep and power-down
   assign wake_req = (st_reg.wakeen[pmrc_pkg::PMRC_WK_PIN]  & (|gpio_s))      // RL9
                   | (st_reg.wakeen[pmrc_pkg::PMRC_WK_WDOG] & misc_s[0])
                   | (st_reg.wakeen[pmrc_pkg::PMRC_WK_USB]  & misc_s[2]);

   // Brownout reset when supply below the chosen reset level
   assign brown_rst = st_reg.brown[pmrc_pkg::PMRC_BR_RSTEN_BIT]
                    & vdd_s[st_reg.brown[pmrc_pkg::PMRC_BR_RSTLVL_LSB +: 2]]; // RL17

   // Any of the chip reset sources; power-on is rst itself
   assign chip_rst_src = pin_low_ok | misc_s[1] | brown_rst; // RL13

   // Next-state logic for registers, sequencing and resets
   always_comb begin
      st_next       = st_reg;
      st_next.finit = 1'b0;
      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            pmrc_pkg::PMRC_ADDR_PCON: begin
               st_next.mode = reg_wdata[pmrc_pkg::PMRC_PCON_MODE_LSB +: 2]; // RL3
               // Lock only sets; cleared by chip reset
               st_next.lock = st_reg.lock | reg_wdata[pmrc_pkg::PMRC_PCON_LOCK_BIT];
            end
            pmrc_pkg::PMRC_ADDR_CLKGATE:  st_next.clkgate  = reg_wdata[NPERIPH-1:0]; // RL4
            pmrc_pkg::PMRC_ADDR_CLKSEL:   st_next.clksel   = reg_wdata[1:0]; // RL2
            pmrc_pkg::PMRC_ADDR_SLEEPCFG: st_next.sleepcfg = reg_wdata[2:0];
            pmrc_pkg::PMRC_ADDR_BROWN:    st_next.brown    = reg_wdata[4:0];
            pmrc_pkg::PMRC_ADDR_WAKEEN:   st_next.wakeen   = reg_wdata[3:0];
            // Write ones to clear reset cause and wake flag
            pmrc_pkg::PMRC_ADDR_STATUS: begin
               st_next.rst_cause = st_reg.rst_cause & ~reg_wdata[3:0];
               st_next.dpd_flag  = st_reg.dpd_flag & ~reg_wdata[4];
            end
            default: ;
         endcase
      end
      // Read data, unmapped reads return zero
      st_next.rdata = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            pmrc_pkg::PMRC_ADDR_PCON:     st_next.rdata = {29'h0, st_reg.lock, st_reg.mode};
            pmrc_pkg::PMRC_ADDR_CLKGATE:  st_next.rdata = 32'(st_reg.clkgate);
            pmrc_pkg::PMRC_ADDR_CLKSEL:   st_next.rdata = {30'h0, st_reg.clksel};
            pmrc_pkg::PMRC_ADDR_SLEEPCFG: st_next.rdata = {29'h0, st_reg.sleepcfg};
            pmrc_pkg::PMRC_ADDR_BROWN:    st_next.rdata = {27'h0, st_reg.brown};
            pmrc_pkg::PMRC_ADDR_WAKEEN:   st_next.rdata = {28'h0, st_reg.wakeen};
            // Brownout level seen, state, flags
            pmrc_pkg::PMRC_ADDR_STATUS:   st_next.rdata = {20'h0, st_reg.state, // RL16
                                                          brownout_irq, 2'h0, st_reg.dpd_flag, st_reg.rst_cause};
            default:                      st_next.rdata = 32'h0000_0000;
         endcase
      end
      // Power state sequencing
      case (cur)
         ST_RUN: begin
            if (core_wfi) begin // RL20
               case (pmrc_pkg::pmrc_mode_t'(st_reg.mode))
                  pmrc_pkg::PMRC_MODE_SLEEP:   st_next.state = 4'(ST_SLEEP);
                  pmrc_pkg::PMRC_MODE_DEEP:    st_next.state = 4'(ST_DEEP);
                  pmrc_pkg::PMRC_MODE_PDOWN:   st_next.state = 4'(ST_PDOWN);
                  // Lock turns deep power-down into plain sleep
                  pmrc_pkg::PMRC_MODE_DEEP_PD: st_next.state = st_reg.lock ? 4'(ST_SLEEP) : 4'(ST_DPD); // RL12
                  default:                     st_next.state = 4'(ST_SLEEP);
               endcase
            end
         end
         // Any interrupt re-enables the core clock directly
         ST_SLEEP: if (core_irq) st_next.state = 4'(ST_RUN); // RL5
         ST_DEEP, ST_PDOWN: if (wake_req) st_next.state = 4'(ST_WAKE); // RL9
         ST_WAKE: if (osc_ready) begin
            st_next.clksel = pmrc_pkg::PMRC_SRC_RC; // RL21
            st_next.state  = 4'(ST_RUN);
         end
         // Only the wake pin leaves deep power-down, through a full restart
         ST_DPD: if (!wpin_s) st_next.dpd_flag = 1'b1; // RL11
         ST_RESET: begin
            if (st_reg.hold != 4'h0) begin
               st_next.hold = st_reg.hold - 4'h1;
            end else begin
               st_next.state = 4'(ST_RUN); // RL15
            end
         end
         default: st_next.state = 4'(ST_RESET);
      endcase
      // Chip reset from any source returns all registers except status to defaults
      if (cur == ST_DPD ? !wpin_s : chip_rst_src) begin // RL13
         st_next.mode     = pmrc_pkg::PMRC_MODE_SLEEP;
         st_next.lock     = 1'b0;
         st_next.clkgate  = NPERIPH'(pmrc_pkg::PMRC_CLKGATE_RST);
         st_next.clksel   = pmrc_pkg::PMRC_CLKSEL_RST; // RL1
         st_next.sleepcfg = pmrc_pkg::PMRC_SLEEPCFG_RST;
         st_next.brown    = pmrc_pkg::PMRC_BROWN_RST;
         st_next.wakeen   = pmrc_pkg::PMRC_WAKEEN_RST;
         st_next.rst_cause = st_reg.rst_cause | {brown_rst, 1'b0, misc_s[1], pin_low_ok};
         st_next.state    = 4'(ST_RESET);
         st_next.hold     = 4'(pmrc_pkg::PMRC_RESET_HOLD_CYC);
      end
      // Flash init pulse when internal reset is entered
      if (st_next.state == 4'(ST_RESET) && cur != ST_RESET) st_next.finit = 1'b1; // RL13
   end

   // Register stage; power-on reset sets the cause flag
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= '{mode: 2'h0, lock: 1'b0, clkgate: '0, clksel: 2'h0, sleepcfg: 3'h0,
                     brown: 5'h00, wakeen: 4'hF, rst_cause: 4'h4, dpd_flag: 1'b0,
                     rdata: 32'h0000_0000, state: 4'h6, hold: 4'h8, finit: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   // Output decode from state
   always_comb begin
      core_clk_en   = (cur == ST_RUN);
      core_rst      = (cur == ST_RESET) || (cur == ST_DPD);
      // Peripherals run in sleep, stop in deeper modes
      periph_clk_en = (cur == ST_RUN || cur == ST_SLEEP) ? st_reg.clkgate : '0; // RL6
      // RC oscillator alive except power-down and deep power-down
      internal_rc_oscillator_en     = !(cur == ST_PDOWN || cur == ST_DPD); // RL1
      internal_rc_oscillator_out_en = (cur == ST_DEEP) ? st_reg.sleepcfg[pmrc_pkg::PMRC_CFG_WDIRC_BIT] // RL7
                                                      : internal_rc_oscillator_en;
      watchdog_oscillator_en = (cur == ST_DEEP || cur == ST_PDOWN)
                             ? st_reg.sleepcfg[pmrc_pkg::PMRC_CFG_WDOSC_BIT] // RL8
                             : (cur != ST_DPD);                              // RL10
      brownout_detector_en = (cur == ST_DEEP || cur == ST_PDOWN)
                           ? st_reg.sleepcfg[pmrc_pkg::PMRC_CFG_BROWN_BIT] : (cur != ST_DPD);
      // Main oscillator and PLL off in deep modes; restarted before core clock
      sysosc_pll_en = !(cur == ST_DEEP || cur == ST_PDOWN || cur == ST_DPD); // RL21
      analog_off    = (cur == ST_DEEP || cur == ST_PDOWN || cur == ST_DPD);  // RL7
      flash_standby = (cur == ST_DEEP);
      flash_off     = (cur == ST_PDOWN || cur == ST_DPD);                    // RL10
      power_off     = (cur == ST_DPD);                                       // RL11
      // Debug port chosen by reset pin level, serial wire off in reset
      bscan_en      = !rpin_s;                                               // RL18
      swd_en        = rpin_s && !core_rst;                                   // RL18
      brownout_irq  = vdd_s[st_reg.brown[pmrc_pkg::PMRC_BR_IRQLVL_LSB +: 2]] && brownout_detector_en; // RL16
   end

   assign reg_rdata      = st_reg.rdata;
   assign clk_sel        = st_reg.clksel;
   assign flash_init     = st_reg.finit;
   assign core_boot_addr = pmrc_pkg::PMRC_BOOT_ADDR; // RL15
endmodule

// ==== dv/pmrc_checker.sv ====
// Port-level property checker for the power mode and reset controller
`timescale 1ns/1ps
module pmrc_checker #(
   parameter int NPERIPH = 32 // Gated peripheral clocks
) (
   input wire logic               mclk,
   input wire logic               rst,
   input wire logic               core_wfi,
   input wire logic               core_clk_en,
   input wire logic               core_rst,
   input wire logic [31:0]        core_boot_addr,
   input wire logic               flash_init,
   input wire logic               flash_standby,
   input wire logic               flash_off,
   input wire logic               analog_off,
   input wire logic               power_off,
   input wire logic [NPERIPH-1:0] periph_clk_en,
   input wire logic               internal_rc_oscillator_en,
   input wire logic [1:0]         clk_sel,
   input wire logic               swd_en
);
   // Single clock domain
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_boot_addr_zero: assert property (core_boot_addr == pmrc_pkg::PMRC_BOOT_ADDR)
      else $error("boot address not zero");
   a_swd_off_reset: assert property (core_rst |-> !swd_en)
      else $error("swd on in reset");
   a_reset_on_rc: assert property (core_rst && !power_off |-> !core_clk_en && internal_rc_oscillator_en)
      else $error("reset clocking wrong");
   a_deep_gates_off: assert property (flash_standby |-> periph_clk_en == '0 && analog_off && internal_rc_oscillator_en)
      else $error("deep-sleep gating wrong");
   a_pdown_gates_off: assert property (flash_off && !power_off |-> periph_clk_en == '0 && analog_off)
      else $error("power-down gating wrong");
   a_dpd_held_reset: assert property (power_off |-> core_rst && flash_off)
      else $error("dpd not held in reset");
   // Core clock stops only for reset or after WFI
   a_stop_needs_wfi: assert property ($fell(core_clk_en) && !core_rst |-> $past(core_wfi) || $past(core_wfi, 2))
      else $error("clock stop without wfi");
   a_flash_init_rst: assert property ($rose(core_rst) && !power_off |-> ##[0:1] flash_init)
      else $error("no flash init on reset");
   a_rc_after_reset: assert property ($fell(core_rst) |-> clk_sel == pmrc_pkg::PMRC_SRC_RC)
      else $error("clock not rc after reset");
endmodule
bind pmrc_top pmrc_checker #(.NPERIPH(NPERIPH)) u_pmrc_checker (.*);

// ==== dv/pmrc_core_model.sv ====
// Behavioural processor core: executes wait-for-interrupt, holds pending interrupts
`timescale 1ns/1ps
module pmrc_core_model (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic wfi_req,     // Bench asks the core to run WFI
   input  wire logic irq_req,     // Bench raises a peripheral interrupt
   input  wire logic core_clk_en, // Core executes only while clocked
   input  wire logic core_rst,
   output logic      core_wfi,
   output logic      core_irq
);
   // A stopped core cannot execute, so WFI needs a running clock
   always_ff @(posedge mclk) begin
      if (rst || core_rst) begin
         core_wfi <= 1'b0;
         core_irq <= 1'b0;
      end else begin
         core_wfi <= wfi_req && core_clk_en;
         // Pending stays until the clocked core services it
         if (irq_req) begin
            core_irq <= 1'b1;
         end else if (core_clk_en) begin
            core_irq <= 1'b0;
         end
      end
   end
endmodule

// ==== dv/pmrc_top_tb.sv ====
// Self-checking bench for the power mode and reset controller
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module pmrc_top_tb;
   localparam logic [7:0] PC = pmrc_pkg::PMRC_ADDR_PCON;   // Short address names
   localparam logic [7:0] ST = pmrc_pkg::PMRC_ADDR_STATUS;
   localparam logic [7:0] CG = pmrc_pkg::PMRC_ADDR_CLKGATE;
   logic        mclk, rst, reg_wr, reg_rd, wfi_req, irq_req, core_wfi, core_irq;
   logic        core_clk_en, core_rst, flash_init, flash_standby, flash_off, analog_off, power_off;
   logic        rc_en, rco_en, pll_en, bod_en, wdosc_en, swd_en, bscan_en, brownout_irq;
   logic        reset_pin_n, wake_pin_n, wdog_irq, wdog_reset, usb_activity;
   logic [7:0]  reg_addr, gpio_wake;
   logic [31:0] reg_wdata, reg_rdata, core_boot_addr, periph_clk_en;
   logic [3:0]  vdd_below;
   logic [1:0]  clk_sel;
   logic [3:0]  cause [3] = '{4'h8, 4'h1, 4'h2}; // Brownout, pin, watchdog
   int          bad_count, cmp_count;
   pmrc_top u_pmrc_top (.*, .internal_rc_oscillator_en(rc_en), .internal_rc_oscillator_out_en(rco_en),
      .watchdog_oscillator_en(wdosc_en), .sysosc_pll_en(pll_en), .brownout_detector_en(bod_en),
      .deep_powerdown_wake_pin_n(wake_pin_n));
   pmrc_core_model u_pmrc_core_model (.*);
   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Verdict in one place
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // Read; data stand in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata & m, e)
   endtask
   // Bounded wait on core reset or core clock level
   task automatic wait_on(input bit on_rst, input logic v);
      for (int i = 0; i < 400; i++) begin
         @(posedge mclk);
         #1;
         if ((on_rst ? core_rst : core_clk_en) === v) return;
      end
      bad_count++;
      tally_and_finish();
   endtask
   // Program a mode, then have the core execute WFI
   task automatic lp(input logic [31:0] m);
      wr(PC, m);
      @(posedge mclk);
      wfi_req <= 1'b1;
      @(posedge mclk);
      wfi_req <= 1'b0;
      repeat (4) @(posedge mclk);
      #1;
   endtask
   initial begin
      {rst, reset_pin_n, wake_pin_n} = 3'h7;
      {reg_wr, reg_rd, wfi_req, irq_req, wdog_irq, wdog_reset, usb_activity} = 7'h00;
      {reg_addr, gpio_wake, vdd_below, reg_wdata} = '0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      wait_on(1'b0, 1'b1);
      `CHK(clk_sel, pmrc_pkg::PMRC_SRC_RC)
      rd(ST, 32'hF, 32'h4);
      rd(pmrc_pkg::PMRC_ADDR_WAKEEN, 32'hF, 32'hF);
      rd(8'h40, 32'hFFFF_FFFF, 32'h0);
      wr(CG, 32'h0000_A5C3);
      rd(CG, 32'hFFFF_FFFF, 32'h0000_A5C3);
      `CHK(periph_clk_en, 32'h0000_A5C3)
      $display("test reset_and_gating done");
      lp(32'h0);
      `CHK(core_clk_en, 1'b0)
      `CHK(periph_clk_en, 32'h0000_A5C3)
      irq_req <= 1'b1;
      @(posedge mclk);
      irq_req <= 1'b0;
      wait_on(1'b0, 1'b1);
      // Deep-sleep with pin wake masked: only watchdog or USB may wake
      wr(pmrc_pkg::PMRC_ADDR_WAKEEN, 32'hE);
      wr(pmrc_pkg::PMRC_ADDR_CLKSEL, 32'h2);
      lp(32'h1);
      `CHK({flash_standby, analog_off, rc_en, rco_en, pll_en, periph_clk_en}, {5'h1C, 32'h0})
      gpio_wake <= 8'h01;
      repeat (40) @(posedge mclk);
      #1;
      `CHK(core_clk_en, 1'b0)
      @(posedge mclk);
      gpio_wake <= 8'h00;
      usb_activity <= 1'b1;
      wait_on(1'b0, 1'b1);
      usb_activity <= 1'b0;
      `CHK(clk_sel, pmrc_pkg::PMRC_SRC_RC)
      // Power-down keeping the watchdog oscillator, watchdog wake
      wr(pmrc_pkg::PMRC_ADDR_SLEEPCFG, 32'h1);
      lp(32'h2);
      `CHK({flash_off, analog_off, wdosc_en, bod_en, periph_clk_en}, {4'hE, 32'h0})
      wdog_irq <= 1'b1;
      wait_on(1'b0, 1'b1);
      wdog_irq <= 1'b0;
      // Locked deep power-down falls back to sleep
      lp(32'h7);
      `CHK({power_off, core_clk_en}, 2'h0)
      irq_req <= 1'b1;
      @(posedge mclk);
      irq_req <= 1'b0;
      wait_on(1'b0, 1'b1);
      $display("test low_power_modes done");
      wr(pmrc_pkg::PMRC_ADDR_BROWN, 32'h19);
      vdd_below <= 4'h2;
      repeat (4) @(posedge mclk);
      #1;
      `CHK(brownout_irq, 1'b1)
      rd(ST, 32'h80, 32'h80);
      // Brownout, 50 ns pin pulse, watchdog resets
      for (int s = 0; s < 3; s++) begin
         @(posedge mclk);
         vdd_below <= (s == 0) ? 4'h4 : 4'h0;
         reset_pin_n <= (s != 1);
         wdog_reset <= (s == 2);
         repeat (2) @(posedge mclk);
         {reset_pin_n, wdog_reset, vdd_below} <= 6'h20;
         wait_on(1'b1, 1'b1);
         `CHK(swd_en, 1'b0)
         wait_on(1'b0, 1'b1);
         rd(ST, {28'h0, cause[s]}, {28'h0, cause[s]});
         rd(CG, 32'hFFFF_FFFF, 32'h0);
      end
      $display("test reset_sources done");
      wr(pmrc_pkg::PMRC_ADDR_CLKSEL, 32'h1);
      lp(32'h3);
      `CHK({power_off, core_rst}, 2'h3)
      gpio_wake <= 8'h01;
      repeat (30) @(posedge mclk);
      #1;
      `CHK(power_off, 1'b1)
      @(posedge mclk);
      {gpio_wake, wake_pin_n} <= 9'h000;
      repeat (4) @(posedge mclk);
      wake_pin_n <= 1'b1;
      wait_on(1'b0, 1'b1);
      `CHK(clk_sel, pmrc_pkg::PMRC_SRC_RC)
      rd(ST, 32'h10, 32'h10);
      reset_pin_n <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      `CHK({bscan_en, swd_en}, 2'h2)
      @(posedge mclk);
      reset_pin_n <= 1'b1;
      wait_on(1'b0, 1'b1);
      `CHK({bscan_en, swd_en}, 2'h1)
      $display("test deep_powerdown_and_debug done");
      tally_and_finish();
   end
endmodule
